/* File: core/wrt_defines.svh */
`ifndef WRT_DEFINES_SVH
`define WRT_DEFINES_SVH

// Register offsets on the register port
`define WRT_OFF_EVT0_HI    6'h1E
`define WRT_OFF_EVT0_LO    6'h1F
`define WRT_OFF_CTRL       6'h20

// Control register field positions
`define WRT_CTRL_PD_BIT    7
`define WRT_CTRL_E1_HI     6
`define WRT_CTRL_E1_LO     4
`define WRT_CTRL_CAL_BIT   3
`define WRT_CTRL_RES_HI    1
`define WRT_CTRL_RES_LO    0

// Reset values
`define WRT_RST_EVT0       16'h876B
`define WRT_RST_PD         1'h1
`define WRT_RST_E1         3'h7
`define WRT_RST_CAL        1'h1
`define WRT_RST_RES        2'h0

// Slow clock divider and calibration length in slow periods
`define WRT_DIV_RATIO      10'd750
`define WRT_CAL_TICKS      8'h04

// Event 1 delays in slow periods, codes 0 to 7
`define WRT_E1_D0          6'h04
`define WRT_E1_D1          6'h06
`define WRT_E1_D2          6'h08
`define WRT_E1_D3          6'h0C
`define WRT_E1_D4          6'h10
`define WRT_E1_D5          6'h18
`define WRT_E1_D6          6'h20
`define WRT_E1_D7          6'h30

// Event 0 prescale limits, one step is 2^(5*code) slow periods
`define WRT_PRE_L0         15'h0000
`define WRT_PRE_L1         15'h001F
`define WRT_PRE_L2         15'h03FF
`define WRT_PRE_L3         15'h7FFF

`endif

/* File: core/wrt_divider.sv */
`timescale 1ns/1ps
`include "wrt_defines.svh"

module wrt_divider (
  input  wire logic i_mclk,     // Crystal reference clock
  input  wire logic i_sys_rst,  // Async reset, active high
  input  wire logic i_en,       // Oscillator powered
  output logic      o_tick      // One pulse per slow period
);
  import wrt_pkg::*;

  wrt_div_t r_reg;              // Registered state
  wrt_div_t r_next;             // Next state

  // Count the reference clock down to the slow rate
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (!i_en) begin            // Powered down: hold the count at zero
      r_next.cnt = 10'h000;
    end else if (r_reg.cnt == `WRT_DIV_RATIO - 10'd1) begin
      r_next.cnt  = 10'h000;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 10'h001;
    end
  end

  // State register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_tick = r_reg.tick;

  // Gap checker helper
  logic [9:0] h_gap;            // Cycles since last tick
  logic       h_seen;           // A tick seen since enable
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      h_gap  <= 10'h000;
      h_seen <= 1'b0;
    end else if (!i_en) begin
      h_gap  <= 10'h000;
      h_seen <= 1'b0;
    end else if (o_tick) begin
      h_gap  <= 10'h000;
      h_seen <= 1'b1;
    end else begin
      h_gap <= h_gap + 10'h001;
    end
  end

  a_tick_gap_exact: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (o_tick && h_seen) |-> (h_gap == 10'd749))
    else $error("slow tick spacing is not 750 cycles");

  a_tick_single_pulse: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_tick |=> !o_tick)
    else $error("slow tick longer than one cycle");

endmodule // wrt_divider

/* File: core/wrt_pkg.sv */
package wrt_pkg;

  // Oscillator and timer phases
  typedef enum logic [1:0] {
    WRT_OFF,
    WRT_CAL,
    WRT_RUN
  } wrt_state_t;

  // Whole state of the timer
  typedef struct packed {
    wrt_state_t  state;    // Phase
    logic        pd;       // Oscillator power-down
    logic [2:0]  e1_code;  // Event 1 delay code
    logic        cal_en;   // Calibration enable
    logic [1:0]  res;      // Event 0 resolution code
    logic [15:0] evt0;     // Event 0 count
    logic [14:0] pre;      // Prescaler within one step
    logic [15:0] steps;    // Steps since last event 0
    logic [5:0]  e1_left;  // Slow periods to event 1
    logic [7:0]  cal_cnt;  // Calibration progress
    logic        ev0;      // Event 0 pulse
    logic        ev1;      // Event 1 pulse
    logic        cal_busy; // Calibration phase level
    logic        running;  // Timing phase level
    logic [7:0]  rdata;    // Read data
  } wrt_regs_t;

  // Divider state
  typedef struct packed {
    logic [9:0] cnt;       // Fast cycles within slow period
    logic       tick;      // Slow period pulse
  } wrt_div_t;

endpackage

/* File: core/wrt_timer.sv */
`timescale 1ns/1ps
`include "wrt_defines.svh"

// Operation
// - Power-down holds oscillator off; clearing starts calibration if its enable bit is written set, else timing
// - Slow clock is reference divided by 750
// - Event 1 follows Event 0 by coded periods
// - Calibration enable bit gates calibration, resets one
// - Resolution scales each Event 0 step
// - Every resolution code accepted and honoured
// - Event 0 interval is count times step, a zero count taken as one
// - Event 0 count resets to 0x876B
module wrt_timer (
  input  wire logic       i_mclk,        // Crystal reference clock, 200 MHz
  input  wire logic       i_sys_rst,     // Async reset, active high
  input  wire logic [5:0] i_reg_addr,    // Register address
  input  wire logic       i_reg_wr,      // Write strobe, one cycle
  input  wire logic [7:0] i_reg_wdata,   // Write data
  output logic      [7:0] o_reg_rdata,   // Read data for addressed register
  output logic            o_first_event_count,      // Event 0 pulse
  output logic            o_second_event_delay,      // Event 1 pulse
  output logic            o_cal_busy,    // Oscillator calibrating
  output logic            o_osc_running  // Oscillator timing, after calibration if its enable bit was set
);
  import wrt_pkg::*;

  wrt_regs_t r_reg;                      // Registered state
  wrt_regs_t r_next;                     // Next state
  logic      slow_tick;                  // Slow period pulse
  logic      osc_on;                     // Oscillator powered

  assign osc_on = !r_reg.pd;

  // Slow oscillator clock
  wrt_divider u_div (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_en      (osc_on),
    .o_tick    (slow_tick)
  );

  // Event 1 delay decode
  function automatic logic [5:0] e1_delay(input logic [2:0] code);
    case (code)
      3'h0:    e1_delay = `WRT_E1_D0;
      3'h1:    e1_delay = `WRT_E1_D1;
      3'h2:    e1_delay = `WRT_E1_D2;
      3'h3:    e1_delay = `WRT_E1_D3;
      3'h4:    e1_delay = `WRT_E1_D4;
      3'h5:    e1_delay = `WRT_E1_D5;
      3'h6:    e1_delay = `WRT_E1_D6;
      default: e1_delay = `WRT_E1_D7;
    endcase
  endfunction

  // Prescale limit per resolution code
  function automatic logic [14:0] pre_limit(input logic [1:0] code);
    case (code)
      2'h0:    pre_limit = `WRT_PRE_L0;
      2'h1:    pre_limit = `WRT_PRE_L1;
      2'h2:    pre_limit = `WRT_PRE_L2;
      default: pre_limit = `WRT_PRE_L3;
    endcase
  endfunction

  // Registers, phases and timers
  always_comb begin
    r_next     = r_reg;
    r_next.ev0 = 1'b0;
    r_next.ev1 = 1'b0;
    // Phase actions: off, calibrating, timing
    case (r_reg.state)
      WRT_OFF: begin                      // Oscillator off
        r_next.pre     = 15'h0000;
        r_next.steps   = 16'h0000;
        r_next.e1_left = 6'h00;
        r_next.cal_cnt = 8'h00;
      end
      WRT_CAL: begin                      // Calibrating
        if (slow_tick) begin
          if (r_reg.cal_cnt == `WRT_CAL_TICKS - 8'h01) begin
            r_next.state = WRT_RUN;
          end else begin
            r_next.cal_cnt = r_reg.cal_cnt + 8'h01;
          end
        end
      end
      WRT_RUN: begin                      // Timing
        if (slow_tick) begin
          if (r_reg.e1_left != 6'h00) begin
            r_next.e1_left = r_reg.e1_left - 6'h01;
            r_next.ev1     = (r_reg.e1_left == 6'h01);
          end
          // At or past the limit, so a smaller code written mid-step cannot wrap the prescaler
          if (r_reg.pre >= pre_limit(r_reg.res)) begin
            r_next.pre = 15'h0000;
            if (({1'b0, r_reg.steps} + 17'h00001) >= {1'b0, r_reg.evt0}) begin
              r_next.steps   = 16'h0000;
              r_next.ev0     = 1'b1;
              r_next.e1_left = e1_delay(r_reg.e1_code);
              r_next.ev1     = 1'b0;
            end else begin
              r_next.steps = r_reg.steps + 16'h0001;
            end
          end else begin
            r_next.pre = r_reg.pre + 15'h0001;
          end
        end
      end
      default: begin
        r_next.state = WRT_OFF;
      end
    endcase
    // Register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        `WRT_OFF_EVT0_HI: r_next.evt0[15:8] = i_reg_wdata;
        `WRT_OFF_EVT0_LO: r_next.evt0[7:0]  = i_reg_wdata;
        `WRT_OFF_CTRL: begin
          r_next.pd      = i_reg_wdata[`WRT_CTRL_PD_BIT];
          r_next.e1_code = i_reg_wdata[`WRT_CTRL_E1_HI:`WRT_CTRL_E1_LO];
          r_next.cal_en  = i_reg_wdata[`WRT_CTRL_CAL_BIT];
          r_next.res     = i_reg_wdata[`WRT_CTRL_RES_HI:`WRT_CTRL_RES_LO];
          if (i_reg_wdata[`WRT_CTRL_PD_BIT]) begin
            r_next.state = WRT_OFF;
          end else if (r_reg.pd) begin    // Power-up edge
            r_next.cal_cnt = 8'h00;
            r_next.state   = i_reg_wdata[`WRT_CTRL_CAL_BIT] ? WRT_CAL : WRT_RUN;
          end
        end
        default: begin                    // Unmapped: ignored
        end
      endcase
    end
    // Read data for the addressed register
    case (i_reg_addr)
      `WRT_OFF_EVT0_HI: r_next.rdata = r_reg.evt0[15:8];
      `WRT_OFF_EVT0_LO: r_next.rdata = r_reg.evt0[7:0];
      `WRT_OFF_CTRL:    r_next.rdata = {r_reg.pd, r_reg.e1_code, r_reg.cal_en, 1'b0, r_reg.res};
      default:          r_next.rdata = 8'h00;
    endcase
    // Status levels registered together with the phase
    r_next.cal_busy = (r_next.state == WRT_CAL);
    r_next.running  = (r_next.state == WRT_RUN);
  end

  // State register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_reg         <= '0;
      r_reg.state   <= WRT_OFF;
      r_reg.pd      <= `WRT_RST_PD;
      r_reg.e1_code <= `WRT_RST_E1;
      r_reg.cal_en  <= `WRT_RST_CAL;
      r_reg.res     <= `WRT_RST_RES;
      r_reg.evt0    <= `WRT_RST_EVT0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_reg_rdata   = r_reg.rdata;
  assign o_first_event_count      = r_reg.ev0;
  assign o_second_event_delay      = r_reg.ev1;
  assign o_cal_busy    = r_reg.cal_busy;
  assign o_osc_running = r_reg.running;

  // Checker helpers: slow periods since event 0, undisturbed interval flag
  logic [31:0] h_per;                    // Slow periods since event 0
  logic        h_clean;                  // No write or stop since event 0
  logic [31:0] h_expect;                 // Expected interval
  logic [15:0] h_cnt1;                   // Count with zero taken as one
  assign h_cnt1   = (r_reg.evt0 == 16'h0000) ? 16'h0001 : r_reg.evt0;
  assign h_expect = {16'h0000, h_cnt1} << (5 * r_reg.res);
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      h_per   <= 32'h00000000;
      h_clean <= 1'b0;
    end else begin
      h_per   <= o_first_event_count ? 32'h00000000 : (slow_tick ? h_per + 32'h00000001 : h_per);
      h_clean <= (i_reg_wr || r_reg.state != WRT_RUN) ? 1'b0 : (o_first_event_count ? 1'b1 : h_clean);
    end
  end

  sequence s_power_up_cal;
    i_reg_wr && i_reg_addr == `WRT_OFF_CTRL && r_reg.pd && !i_reg_wdata[7] && i_reg_wdata[3];
  endsequence
  sequence s_power_up_nocal;
    i_reg_wr && i_reg_addr == `WRT_OFF_CTRL && r_reg.pd && !i_reg_wdata[7] && !i_reg_wdata[3];
  endsequence

  a_pd_holds_off: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (r_reg.pd && !(i_reg_wr && i_reg_addr == `WRT_OFF_CTRL && !i_reg_wdata[`WRT_CTRL_PD_BIT]))
      |=> (!o_first_event_count && !o_second_event_delay && !o_osc_running))
    else $error("timer active while powered down");

  a_cal_on_wake: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_power_up_cal |=> o_cal_busy ##1 o_cal_busy)
    else $error("power-up did not start calibration");

  a_cal_skip_wake: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_power_up_nocal |=> (o_osc_running && !o_cal_busy))
    else $error("calibration ran while disabled");

  a_cal_ends_run: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $fell(o_cal_busy) |-> (o_osc_running || r_reg.pd))
    else $error("calibration end did not start timing");

  a_ev1_delay_code: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (o_second_event_delay && h_clean) |-> (h_per[5:0] == e1_delay(r_reg.e1_code)))
    else $error("event 1 delay wrong");

  a_ev0_interval_exact: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (o_first_event_count && h_clean) |-> (h_per == h_expect))
    else $error("event 0 interval wrong");

  a_res_accept_all: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_reg_wr && i_reg_addr == `WRT_OFF_CTRL) |=> (r_reg.res == $past(i_reg_wdata[1:0])))
    else $error("resolution code not accepted");

  a_rd_ctrl_fields: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_reg_addr == `WRT_OFF_CTRL) |=> (o_reg_rdata[2] == 1'b0 &&
      o_reg_rdata[1:0] == $past(r_reg.res) && o_reg_rdata[7] == $past(r_reg.pd)))
    else $error("control read data wrong");

  a_ev0_restarts: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_first_event_count |-> (r_reg.steps == 16'h0000))
    else $error("event 0 counter not restarted");

endmodule // wrt_timer

/* File: tb/wrt_timer_tb.sv */
`timescale 1ns/1ps
`include "wrt_defines.svh"

module testbench;
  import wrt_pkg::*;

  localparam int DIV = 750;        // Fast cycles per slow period

  logic       i_mclk      = 1'b0;  // Reference clock
  logic       i_sys_rst   = 1'b1;  // Reset, held at start
  logic [5:0] i_reg_addr  = 6'h00; // Register address
  logic       i_reg_wr    = 1'b0;  // Write strobe
  logic [7:0] i_reg_wdata = 8'h00; // Write data
  logic [7:0] o_reg_rdata;         // Read data
  logic       o_first_event_count;            // Event 0 pulse
  logic       o_second_event_delay;            // Event 1 pulse
  logic       o_cal_busy;          // Calibration level
  logic       o_osc_running;       // Timing level
  wire  [3:0] mon = {o_osc_running, o_cal_busy, o_second_event_delay, o_first_event_count}; // Watched outputs
  int         err_count    = 0;    // Mismatches
  int         total_checks = 0;    // Comparisons
  int         n;                   // Measured cycles
  int         m;                   // Second measurement

  wrt_timer u_wrt_timer (
    .i_mclk        (i_mclk),
    .i_sys_rst     (i_sys_rst),
    .i_reg_addr    (i_reg_addr),
    .i_reg_wr      (i_reg_wr),
    .i_reg_wdata   (i_reg_wdata),
    .o_reg_rdata   (o_reg_rdata),
    .o_first_event_count      (o_first_event_count),
    .o_second_event_delay      (o_second_event_delay),
    .o_cal_busy    (o_cal_busy),
    .o_osc_running (o_osc_running)
  );

  // Clock at 200 MHz
  always #2.5 i_mclk = ~i_mclk;

  // Compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // One register write, strobe for one cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    @(negedge i_mclk);
    i_reg_wr    = 1'b0;
  endtask

  // Read a register once its data has settled
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(negedge i_mclk);
    i_reg_addr = a;
    repeat (2) @(negedge i_mclk);
    chk({8'h00, o_reg_rdata}, {8'h00, exp});
  endtask

  // Count cycles until a watched output is high, bounded
  task automatic wait_sig(input int sel, input int lim, output int cnt);
    cnt = 0;
    forever begin
      @(negedge i_mclk);
      cnt++;
      if (mon[sel] === 1'b1) break;
      if (cnt >= lim) break;
    end
  endtask

  // Reset values and unmapped read
  task automatic t_reset();
    rd_chk(`WRT_OFF_EVT0_HI, 8'h87);
    rd_chk(`WRT_OFF_EVT0_LO, 8'h6B);
    rd_chk(`WRT_OFF_CTRL, 8'hF8);
    rd_chk(6'h3F, 8'h00);
    chk({15'h0, o_osc_running}, 16'h0000);
  endtask

  // Field readback with oscillator held down
  task automatic t_fields();
    logic [7:0] v;
    wr(`WRT_OFF_CTRL, 8'hFF);
    rd_chk(`WRT_OFF_CTRL, 8'hFB);
    for (int k = 0; k < 8; k++) begin
      v = {1'b1, 3'(k), 1'b1, 1'b0, 2'(k % 4)};
      wr(`WRT_OFF_CTRL, v);
      rd_chk(`WRT_OFF_CTRL, v);
    end
  endtask

  // Power up with calibration
  task automatic t_cal();
    wr(`WRT_OFF_EVT0_HI, 8'h00);
    wr(`WRT_OFF_EVT0_LO, 8'h0D);
    wr(`WRT_OFF_CTRL, 8'h38);
    wait_sig(2, 4, n);
    chk({15'h0, o_cal_busy}, 16'h0001);
    wait_sig(3, 5 * DIV, n);
    chk(16'(n), 16'(`WRT_CAL_TICKS * DIV));
    chk({14'h0, o_cal_busy, o_osc_running}, 16'h0001);
  endtask

  // Event 1 delay and Event 0 period, count 13, delay code 3
  task automatic t_events();
    wait_sig(0, 14 * DIV, n);
    wait_sig(1, 14 * DIV, n);
    chk(16'(n), 16'(12 * DIV));
    wait_sig(0, 14 * DIV, m);
    chk(16'(n + m), 16'(13 * DIV));
  endtask

  // Resolution code 1 while running, count 1
  task automatic t_res();
    wr(`WRT_OFF_EVT0_LO, 8'h01);
    wr(`WRT_OFF_CTRL, 8'h39);
    wait_sig(0, 34 * DIV, n);
    wait_sig(0, 34 * DIV, n);
    chk(16'(n), 16'(32 * DIV));
  endtask

  // Power down stops timing at once
  task automatic t_stop();
    wr(`WRT_OFF_CTRL, 8'hB8);
    @(negedge i_mclk);
    chk({14'h0, o_cal_busy, o_osc_running}, 16'h0000);
    wait_sig(0, 2 * DIV, n);
    chk(16'(n), 16'(2 * DIV));
  endtask

  // Power up without calibration, count 1 at finest step
  task automatic t_nocal();
    wr(`WRT_OFF_CTRL, 8'h30);
    wait_sig(3, 4, n);
    chk({14'h0, o_cal_busy, o_osc_running}, 16'h0001);
    wait_sig(0, 2 * DIV, n);
    wait_sig(0, 2 * DIV, n);
    chk(16'(n), 16'(DIV));
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    t_reset();
    t_fields();
    t_cal();
    t_events();
    t_res();
    t_stop();
    t_nocal();
    print_verdict();
  end

  // Hang guard, past the expected run of about 74000 cycles
  initial begin
    #(90000 * 5);
    err_count++;
    print_verdict();
  end

endmodule // testbench
